/* File: tec_params.svh */
// Constants shared by both ends of the end-to-end CRC block.
// Assumes it is included by bare name from every design file that uses its constants.
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH

// Digest-present bit in the first header word.
`define TEC_TD_BIT      15
// Enable bits in the error capabilities and control word.
`define TEC_GEN_BIT     6
`define TEC_CHK_BIT     8
`define TEC_CRC_INIT    32'hFFFF_FFFF
`define TEC_CRC_POLY    32'h04C1_1DB7
// Packet store and transmit FIFO sizes in words.
`define TEC_BUF_DEPTH   32
`define TEC_FIFO_DEPTH  32
// Error message packet sent by the application, four words.
`define TEC_MSG_LEN     2'h3
`define TEC_MSG_DW0     32'h3000_0000
`define TEC_MSG_DW1     32'h0000_0031
`define TEC_MSG_DW2     32'h0000_0000
`define TEC_MSG_DW3     32'h0000_0000

`endif

/* File: tec_pkg.sv */
// Types and the CRC step shared by both ends.
// Assumes tec_params.svh is on the include path.
`include "tec_params.svh"

package tec_pkg;

	typedef logic [31:0] tec_word_t;

	typedef enum logic {RX_FILL, RX_DRAIN} tec_rx_st_t;
	typedef enum logic {TX_PASS, TX_CRC} tec_tx_st_t;
	typedef enum logic [1:0] {AT_IDLE, AT_USR, AT_CRC, AT_MSG} tec_at_st_t;

	// One 32-bit step of the CRC, most significant bit first.
	function automatic tec_word_t tec_crc(input tec_word_t c, input tec_word_t d);
		tec_word_t r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			if (r[31] ^ d[i]) begin
				r = {r[30:0], 1'b0} ^ `TEC_CRC_POLY;
			end else begin
				r = {r[30:0], 1'b0};
			end
		end
		return r;
	endfunction

endpackage

/* File: tec_if.sv */
// Streaming packet ports between the transaction layer and the application.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface tec_if;
	logic        rx_valid;
	logic        rx_ready;
	logic [31:0] rx_data;
	logic        rx_sop;
	logic        rx_eop;
	logic        rx_ecrc_err;
	logic        tx_valid;
	logic        tx_ready;
	logic [31:0] tx_data;
	logic        tx_sop;
	logic        tx_eop;

	modport dev (
		output rx_valid, rx_data, rx_sop, rx_eop, rx_ecrc_err,
		input  rx_ready,
		input  tx_valid, tx_data, tx_sop, tx_eop,
		output tx_ready
	);

	modport app (
		input  rx_valid, rx_data, rx_sop, rx_eop, rx_ecrc_err,
		output rx_ready,
		output tx_valid, tx_data, tx_sop, tx_eop,
		input  tx_ready
	);
endinterface

/* File: tec_fifo.sv */
// Synchronous valid/ready FIFO.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module tec_fifo #(
	parameter int W     = 34,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rp_r];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= AW'((wp_r + 1'b1) % DEPTH);
			end
			if (pop) begin
				rp_r <= AW'((rp_r + 1'b1) % DEPTH);
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // tec_fifo

/* File: tec_dev.sv */
// Transaction-layer end of the end-to-end CRC block: receive check and
// strip, transmit generate or forward.
// Assumes the link streams are on clk and the application sits on tec_if.
//
// Behaviour
// - Checking on: bad digest flagged, packet dropped.
// - Checking off: no detection, always delivered.
// - Receive forwarding on: digest delivered with packet.
// - Receive forwarding off: digest stripped before delivery.
// - Generation without forwarding: append CRC, set bit.
// - Digest bit one means digest present.
// - Transmit forwarding: application digest passed unchanged.
// - Forwarding: application computes and checks digests.
// - Application uses only supported transmit combinations.
// - All digest features need error reporting capability.
// - Application reports digest errors with message.
// - Enables come from the error control word.
`timescale 1ns/1ps
`include "tec_params.svh"

module tec_dev (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        aer_impl,
	input  wire logic [31:0] aer_ctl,
	input  wire logic        rx_fwd_opt,
	input  wire logic        tx_fwd_opt,
	input  wire logic        lnk_rx_valid,
	output logic             lnk_rx_ready,
	input  wire logic [31:0] lnk_rx_data,
	input  wire logic        lnk_rx_sop,
	input  wire logic        lnk_rx_eop,
	output logic             lnk_tx_valid,
	input  wire logic        lnk_tx_ready,
	output logic [31:0]      lnk_tx_data,
	output logic             lnk_tx_sop,
	output logic             lnk_tx_eop,
	tec_if.dev               app
);

	logic chk_en;
	logic gen_en;
	logic rfwd;
	logic tfwd;

	// Every digest feature is gated by the error reporting option.
	assign chk_en = aer_impl & aer_ctl[`TEC_CHK_BIT];
	assign gen_en = aer_impl & aer_ctl[`TEC_GEN_BIT];
	assign rfwd   = aer_impl & rx_fwd_opt;
	assign tfwd   = aer_impl & tx_fwd_opt;

	// Receive side: a whole packet is stored before it is released, since
	// a bad digest is only known at the last word. Packets are limited to
	// the store depth.
	tec_pkg::tec_word_t   mem [`TEC_BUF_DEPTH];
	tec_pkg::tec_rx_st_t  rs_r;
	logic [5:0]           wp_r;
	logic [5:0]           rp_r;
	logic [5:0]           len_r;
	logic                 strip_r;
	logic                 td_r;
	tec_pkg::tec_word_t   rcrc_r;
	logic                 err_r;
	logic                 rv_r;
	tec_pkg::tec_word_t   rd_r;
	logic                 rsop_r;
	logic                 reop_r;
	logic                 rx_acc;
	logic                 td_now;
	logic                 bad;
	logic                 drop;
	logic                 rload;
	tec_pkg::tec_word_t   rword;

	assign lnk_rx_ready = (rs_r == tec_pkg::RX_FILL);
	assign rx_acc       = lnk_rx_valid & lnk_rx_ready;
	// The header's digest bit tells whether a digest word ends the packet.
	assign td_now       = lnk_rx_sop ? lnk_rx_data[`TEC_TD_BIT] : td_r;
	assign bad          = td_now & (lnk_rx_data != ~rcrc_r);
	assign drop         = chk_en & bad;
	assign rload        = (rs_r == tec_pkg::RX_DRAIN) & (!rv_r | app.rx_ready);

	always_ff @(posedge clk) begin
		if (rx_acc) begin
			mem[wp_r[4:0]] <= lnk_rx_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rcrc_r <= `TEC_CRC_INIT;
			td_r   <= 1'b0;
		end else if (rx_acc) begin
			rcrc_r <= tec_pkg::tec_crc(lnk_rx_sop ? `TEC_CRC_INIT : rcrc_r, lnk_rx_data);
			td_r   <= td_now;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rs_r    <= tec_pkg::RX_FILL;
			wp_r    <= 6'h00;
			len_r   <= 6'h00;
			strip_r <= 1'b0;
		end else if (rx_acc) begin
			if (!lnk_rx_eop) begin
				wp_r <= wp_r + 6'h01;
			end else begin
				wp_r <= 6'h00;
				if (!drop) begin
					// A packet without a digest is never stripped.
					strip_r <= td_now & !rfwd;
					len_r   <= wp_r + 6'h01 - {5'h00, td_now & !rfwd};
					rs_r    <= tec_pkg::RX_DRAIN;
				end
			end
		end else if (rload && rp_r == len_r - 6'h01) begin
			rs_r <= tec_pkg::RX_FILL;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			err_r <= 1'b0;
		end else begin
			err_r <= rx_acc & lnk_rx_eop & drop;
		end
	end

	always_comb begin
		rword = mem[rp_r[4:0]];
		if (rp_r == 6'h00 && strip_r) begin
			rword[`TEC_TD_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rp_r   <= 6'h00;
			rv_r   <= 1'b0;
			rd_r   <= 32'h0000_0000;
			rsop_r <= 1'b0;
			reop_r <= 1'b0;
		end else if (rload) begin
			rv_r   <= 1'b1;
			rd_r   <= rword;
			rsop_r <= (rp_r == 6'h00);
			reop_r <= (rp_r == len_r - 6'h01);
			rp_r   <= (rp_r == len_r - 6'h01) ? 6'h00 : rp_r + 6'h01;
		end else if (app.rx_ready) begin
			rv_r <= 1'b0;
		end
	end

	assign app.rx_valid    = rv_r;
	assign app.rx_data     = rd_r;
	assign app.rx_sop      = rsop_r;
	assign app.rx_eop      = reop_r;
	assign app.rx_ecrc_err = err_r;

	// Transmit side: application words are buffered, then edited on the
	// way to the link.
	logic                 f_valid;
	logic                 f_ready;
	logic [33:0]          f_data;
	tec_pkg::tec_tx_st_t  ts_r;
	tec_pkg::tec_word_t   tcrc_r;
	logic                 tgen_r;
	logic                 tgen_now;
	logic                 slot;
	logic                 pop;
	tec_pkg::tec_word_t   wmod;
	logic                 tv_r;
	tec_pkg::tec_word_t   td_out_r;
	logic                 tsop_r;
	logic                 teop_r;

	tec_fifo #(
		.W     (34),
		.DEPTH (`TEC_FIFO_DEPTH)
	) u_txq (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (app.tx_valid),
		.in_ready  (app.tx_ready),
		.in_data   ({app.tx_eop, app.tx_sop, app.tx_data}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	assign slot     = !tv_r | lnk_tx_ready;
	assign f_ready  = (ts_r == tec_pkg::TX_PASS) & slot;
	assign pop      = f_valid & f_ready;
	// Generation mode is fixed for a packet at its first word.
	assign tgen_now = f_data[32] ? (gen_en & !tfwd) : tgen_r;

	always_comb begin
		wmod = f_data[31:0];
		if (f_data[32] && !tfwd) begin
			// Generate sets the bit; with both off the bit is cleared.
			wmod[`TEC_TD_BIT] = gen_en;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tcrc_r <= `TEC_CRC_INIT;
			tgen_r <= 1'b0;
		end else if (pop) begin
			tcrc_r <= tec_pkg::tec_crc(f_data[32] ? `TEC_CRC_INIT : tcrc_r, wmod);
			tgen_r <= tgen_now;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ts_r     <= tec_pkg::TX_PASS;
			tv_r     <= 1'b0;
			td_out_r <= 32'h0000_0000;
			tsop_r   <= 1'b0;
			teop_r   <= 1'b0;
		end else begin
			case (ts_r)
				tec_pkg::TX_PASS: begin
					if (pop) begin
						tv_r     <= 1'b1;
						td_out_r <= wmod;
						tsop_r   <= f_data[32];
						teop_r   <= f_data[33] & !tgen_now;
						if (f_data[33] && tgen_now) begin
							ts_r <= tec_pkg::TX_CRC;
						end
					end else if (lnk_tx_ready) begin
						tv_r <= 1'b0;
					end
				end
				tec_pkg::TX_CRC: begin
					if (slot) begin
						tv_r     <= 1'b1;
						td_out_r <= ~tcrc_r;
						tsop_r   <= 1'b0;
						teop_r   <= 1'b1;
						ts_r     <= tec_pkg::TX_PASS;
					end
				end
				default: begin
					ts_r <= tec_pkg::TX_PASS;
				end
			endcase
		end
	end

	assign lnk_tx_valid = tv_r;
	assign lnk_tx_data  = td_out_r;
	assign lnk_tx_sop   = tsop_r;
	assign lnk_tx_eop   = teop_r;

endmodule // tec_dev

/* File: tec_app.sv */
// Application end: digest work in forwarding mode and error reporting.
// Assumes fwd_mode matches the transaction layer's forwarding options.
`timescale 1ns/1ps
`include "tec_params.svh"

module tec_app (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        fwd_mode,
	input  wire logic        usr_tx_valid,
	output logic             usr_tx_ready,
	input  wire logic [31:0] usr_tx_data,
	input  wire logic        usr_tx_sop,
	input  wire logic        usr_tx_eop,
	output logic             usr_rx_valid,
	input  wire logic        usr_rx_ready,
	output logic [31:0]      usr_rx_data,
	output logic             usr_rx_sop,
	output logic             usr_rx_eop,
	output logic             usr_crc_bad,
	tec_if.app               dev
);

	tec_pkg::tec_word_t  acrc_r;
	logic                atd_r;
	logic                atd_now;
	logic                bad_r;
	logic                racc;
	logic                pend_r;

	assign usr_rx_valid = dev.rx_valid;
	assign usr_rx_data  = dev.rx_data;
	assign usr_rx_sop   = dev.rx_sop;
	assign usr_rx_eop   = dev.rx_eop;
	assign dev.rx_ready = usr_rx_ready;
	assign usr_crc_bad  = bad_r;
	assign racc         = dev.rx_valid & usr_rx_ready;
	assign atd_now      = dev.rx_sop ? dev.rx_data[`TEC_TD_BIT] : atd_r;

	// Checked only in forwarding mode; the packet is already delivered.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acrc_r <= `TEC_CRC_INIT;
			atd_r  <= 1'b0;
			bad_r  <= 1'b0;
		end else begin
			bad_r <= racc & dev.rx_eop & fwd_mode & atd_now & (dev.rx_data != ~acrc_r);
			if (racc) begin
				acrc_r <= tec_pkg::tec_crc(dev.rx_sop ? `TEC_CRC_INIT : acrc_r, dev.rx_data);
				atd_r  <= atd_now;
			end
		end
	end

	tec_pkg::tec_at_st_t st_r;
	tec_pkg::tec_word_t  tcrc_r;
	tec_pkg::tec_word_t  w;
	tec_pkg::tec_word_t  msg;
	logic [1:0]          idx_r;
	logic                slot;
	logic                uacc;
	logic                v_r;
	tec_pkg::tec_word_t  d_r;
	logic                sop_r;
	logic                eop_r;

	assign slot = !v_r | dev.tx_ready;
	assign usr_tx_ready = slot & ((st_r == tec_pkg::AT_USR) | ((st_r == tec_pkg::AT_IDLE) & !pend_r));
	assign uacc = usr_tx_valid & usr_tx_ready;

	always_comb begin
		w = usr_tx_data;
		// Outside forwarding mode the user's digest bit goes through without a
		// digest word, and the transaction layer sets or clears it as configured.
		if (usr_tx_sop && fwd_mode) begin
			w[`TEC_TD_BIT] = 1'b1;
		end
		case (idx_r)
			2'h0:    msg = `TEC_MSG_DW0;
			2'h1:    msg = `TEC_MSG_DW1;
			2'h2:    msg = `TEC_MSG_DW2;
			default: msg = `TEC_MSG_DW3;
		endcase
	end

	// A new error wins over the clear of the pending report.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_r <= 1'b0;
		end else if (bad_r || dev.rx_ecrc_err) begin
			pend_r <= 1'b1;
		end else if (st_r == tec_pkg::AT_MSG && slot && idx_r == `TEC_MSG_LEN) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tcrc_r <= `TEC_CRC_INIT;
		end else if (uacc) begin
			tcrc_r <= tec_pkg::tec_crc(usr_tx_sop ? `TEC_CRC_INIT : tcrc_r, w);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r  <= tec_pkg::AT_IDLE;
			idx_r <= 2'h0;
			v_r   <= 1'b0;
			d_r   <= 32'h0000_0000;
			sop_r <= 1'b0;
			eop_r <= 1'b0;
		end else begin
			if (dev.tx_ready) begin
				v_r <= 1'b0;
			end
			case (st_r)
				tec_pkg::AT_IDLE, tec_pkg::AT_USR: begin
					if (st_r == tec_pkg::AT_IDLE && pend_r && slot) begin
						idx_r <= 2'h0;
						st_r  <= tec_pkg::AT_MSG;
					end else if (uacc) begin
						v_r   <= 1'b1;
						d_r   <= w;
						sop_r <= usr_tx_sop;
						eop_r <= usr_tx_eop & !fwd_mode;
						if (usr_tx_eop) begin
							st_r <= fwd_mode ? tec_pkg::AT_CRC : tec_pkg::AT_IDLE;
						end else begin
							st_r <= tec_pkg::AT_USR;
						end
					end
				end
				tec_pkg::AT_CRC: begin
					if (slot) begin
						v_r   <= 1'b1;
						d_r   <= ~tcrc_r;
						sop_r <= 1'b0;
						eop_r <= 1'b1;
						st_r  <= tec_pkg::AT_IDLE;
					end
				end
				tec_pkg::AT_MSG: begin
					if (slot) begin
						v_r   <= 1'b1;
						d_r   <= msg;
						sop_r <= (idx_r == 2'h0);
						eop_r <= (idx_r == `TEC_MSG_LEN);
						idx_r <= idx_r + 2'h1;
						if (idx_r == `TEC_MSG_LEN) begin
							st_r <= tec_pkg::AT_IDLE;
						end
					end
				end
				default: begin
					st_r <= tec_pkg::AT_IDLE;
				end
			endcase
		end
	end

	assign dev.tx_valid = v_r;
	assign dev.tx_data  = d_r;
	assign dev.tx_sop   = sop_r;
	assign dev.tx_eop   = eop_r;

endmodule // tec_app

/* File: tec_chk.sv */
// Concurrent checks on the stream signals between the two ends.
// Assumes the signals of one tec_if instance, all on clk.
`timescale 1ns/1ps

module tec_chk (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        rx_valid,
	input  wire logic        rx_ready,
	input  wire logic [31:0] rx_data,
	input  wire logic        rx_sop,
	input  wire logic        rx_eop,
	input  wire logic        rx_ecrc_err,
	input  wire logic        tx_valid,
	input  wire logic        tx_ready,
	input  wire logic [31:0] tx_data,
	input  wire logic        tx_sop,
	input  wire logic        tx_eop
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_rx_wait; rx_valid && !rx_ready; endsequence
	sequence s_rx_last; rx_valid && rx_ready && rx_eop; endsequence
	sequence s_tx_wait; tx_valid && !tx_ready; endsequence
	sequence s_tx_last; tx_valid && tx_ready && tx_eop; endsequence

	property p_rx_hold; s_rx_wait |=> rx_valid && $stable({rx_data, rx_sop, rx_eop}); endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx word moved while stalled");
	property p_rx_next; s_rx_last |=> !rx_valid || rx_sop; endproperty
	a_rx_next: assert property (p_rx_next) else $error("rx packet without start");
	property p_rx_first; $rose(rx_valid) |-> rx_sop; endproperty
	a_rx_first: assert property (p_rx_first) else $error("rx starts mid packet");
	property p_drop; rx_ecrc_err |-> !rx_valid; endproperty
	a_drop: assert property (p_drop) else $error("dropped packet shown");
	property p_err_pulse; rx_ecrc_err |=> !rx_ecrc_err; endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error flag too long");
	property p_err_idle; rx_ecrc_err |-> !$past(rx_valid); endproperty
	a_err_idle: assert property (p_err_idle) else $error("error while delivering");
	property p_tx_hold; s_tx_wait |=> tx_valid && $stable({tx_data, tx_sop, tx_eop}); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx word moved while stalled");
	property p_tx_next; s_tx_last |=> !tx_valid || tx_sop; endproperty
	a_tx_next: assert property (p_tx_next) else $error("tx packet without start");
	property p_full; $fell(tx_ready) |-> $past(tx_valid && tx_ready); endproperty
	a_full: assert property (p_full) else $error("tx refused without a push");
endmodule // tec_chk

/* File: test_tlp_ecrc_check_generate.sv */
// Joins both ends over tec_if, drives the link and user sides.
// Assumes the design files and tec_chk.sv are compiled first.
`timescale 1ns/1ps
`include "tec_params.svh"

module test_tlp_ecrc_check_generate;
	logic        clk = 1'h0, arst_n = 1'h0, aer_impl = 1'h1, fwd = 1'h0;
	logic        stall = 1'h0, hold = 1'h0, dlnk = 1'h0, dv = 1'h0, ds = 1'h0, de = 1'h0;
	logic        usr_rx_ready = 1'h1, lnk_tx_ready = 1'h1, lnk_rx_ready, lnk_tx_valid;
	logic        lnk_tx_sop, lnk_tx_eop, usr_tx_ready, usr_rx_valid, usr_rx_sop;
	logic        usr_rx_eop, usr_crc_bad;
	logic [31:0] aer_ctl = 32'h0, dd = 32'h0, lnk_tx_data, usr_rx_data;
	logic [32:0] rxq[$], txq[$];
	logic        rsq[$], tsq[$];
	int          fails = 0, num_checks = 0, errs = 0, bads = 0;
	wire logic   rdy = dlnk ? lnk_rx_ready : usr_tx_ready;
	localparam logic [31:0] MSG [4] = '{`TEC_MSG_DW0, `TEC_MSG_DW1, `TEC_MSG_DW2, `TEC_MSG_DW3};

	tec_if u_tec_if ();
	tec_dev u_tec_dev (.clk(clk), .arst_n(arst_n), .aer_impl(aer_impl), .aer_ctl(aer_ctl),
		.rx_fwd_opt(fwd), .tx_fwd_opt(fwd), .lnk_rx_valid(dv & dlnk),
		.lnk_rx_ready(lnk_rx_ready), .lnk_rx_data(dd), .lnk_rx_sop(ds), .lnk_rx_eop(de),
		.lnk_tx_valid(lnk_tx_valid), .lnk_tx_ready(lnk_tx_ready), .lnk_tx_data(lnk_tx_data),
		.lnk_tx_sop(lnk_tx_sop), .lnk_tx_eop(lnk_tx_eop), .app(u_tec_if.dev));
	tec_app u_tec_app (.clk(clk), .arst_n(arst_n), .fwd_mode(fwd), .usr_tx_valid(dv & !dlnk),
		.usr_tx_ready(usr_tx_ready), .usr_tx_data(dd), .usr_tx_sop(ds), .usr_tx_eop(de),
		.usr_rx_valid(usr_rx_valid), .usr_rx_ready(usr_rx_ready), .usr_rx_data(usr_rx_data),
		.usr_rx_sop(usr_rx_sop), .usr_rx_eop(usr_rx_eop), .usr_crc_bad(usr_crc_bad),
		.dev(u_tec_if.app));
	tec_chk u_tec_chk (.clk(clk), .arst_n(arst_n), .rx_valid(u_tec_if.rx_valid),
		.rx_ready(u_tec_if.rx_ready), .rx_data(u_tec_if.rx_data), .rx_sop(u_tec_if.rx_sop),
		.rx_eop(u_tec_if.rx_eop), .rx_ecrc_err(u_tec_if.rx_ecrc_err),
		.tx_valid(u_tec_if.tx_valid), .tx_ready(u_tec_if.tx_ready),
		.tx_data(u_tec_if.tx_data), .tx_sop(u_tec_if.tx_sop), .tx_eop(u_tec_if.tx_eop));

	always #12.5 clk = ~clk;

	always @(negedge clk) begin
		usr_rx_ready <= stall ? ~usr_rx_ready : 1'h1;
		lnk_tx_ready <= !hold;
	end

	always @(posedge clk) begin
		if (usr_rx_valid === 1'h1 && usr_rx_ready === 1'h1) begin
			rxq.push_back({usr_rx_eop, usr_rx_data});
			rsq.push_back(usr_rx_sop);
		end
		if (lnk_tx_valid === 1'h1 && lnk_tx_ready === 1'h1) begin
			txq.push_back({lnk_tx_eop, lnk_tx_data});
			tsq.push_back(lnk_tx_sop);
		end
		if (u_tec_if.rx_ecrc_err === 1'h1) errs++;
		if (usr_crc_bad === 1'h1) bads++;
	end

	function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) r = (r << 1) ^ ((r[31] ^ d[i]) ? `TEC_CRC_POLY : 32'h0);
		return r;
	endfunction

	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Ready depends on state only, so its value just after the falling edge holds at the
	// next rising edge; this avoids racing the design's own update at that edge.
	task automatic send(input logic lnk, input logic [31:0] w[$]);
		dlnk = lnk;
		foreach (w[i]) begin
			dv <= 1'h1;
			dd <= w[i];
			ds <= (i == 0);
			de <= (i == w.size() - 1);
			#1;
			while (rdy !== 1'h1) begin
				@(negedge clk);
				#1;
			end
			@(negedge clk);
		end
		dv <= 1'h0;
		dd <= ~dd;
	endtask

	task automatic rx_case(input logic ce, input logic fe, input logic td, input logic bad);
		logic [31:0] w[$];
		logic [32:0] e[$];
		logic [31:0] c;
		aer_ctl = 32'h0;
		aer_ctl[`TEC_CHK_BIT] = ce;
		fwd = fe;
		stall = 1'h1;
		rxq = {};
		txq = {};
		rsq = {};
		tsq = {};
		errs = 0;
		bads = 0;
		w = '{{16'h4000, td, 15'h0002}, 32'h0A0B_0C0D, 32'h1234_5678};
		c = `TEC_CRC_INIT;
		foreach (w[i]) c = crc(c, w[i]);
		if (td) w.push_back(~c ^ {31'h0, bad});
		if (!(td && bad && ce)) begin
			foreach (w[i]) if (i < 3 || fe) e.push_back({1'h0, w[i]});
			e[0][15] = td & fe;
			e[e.size() - 1][32] = 1'h1;
		end
		send(1'h1, w);
		repeat (60) @(negedge clk);
		chk("rx count", 33'(e.size()), 33'(rxq.size()));
		foreach (e[i]) chk("rx word", e[i], rxq[i]);
		foreach (e[i]) chk("rx start", 33'(i == 0), 33'(rsq[i]));
		chk("rx error", 33'(td & bad & ce), 33'(errs));
		chk("app flag", 33'(td & bad & fe & !ce), 33'(bads));
		chk("report count", (td & bad & (ce | fe)) ? 33'h4 : 33'h0, 33'(txq.size()));
		if (td & bad & (ce | fe)) begin
			foreach (MSG[i]) chk("report", 33'(MSG[i]), txq[i] & 33'h0FFFF7FFF);
			foreach (MSG[i]) chk("report start", 33'(i == 0), 33'(tsq[i]));
		end
		stall = 1'h0;
	endtask

	task automatic tx_case(input logic gen, input logic fe, input logic aer, input int n);
		logic [31:0] w[$];
		logic [32:0] e[$];
		logic [31:0] c;
		logic        td;
		aer_impl = aer;
		aer_ctl = 32'h0;
		aer_ctl[`TEC_GEN_BIT] = gen;
		fwd = fe;
		hold <= (n > 32);
		txq = {};
		tsq = {};
		td = fe | (gen & aer);
		for (int i = 0; i < n; i++) begin
			w.push_back(32'h5A00_8000 + 32'(i));
			e.push_back({1'h0, w[i]});
		end
		e[0][15] = td;
		c = `TEC_CRC_INIT;
		foreach (e[i]) c = crc(c, e[i][31:0]);
		if (td) e.push_back({1'h0, ~c});
		e[e.size() - 1][32] = 1'h1;
		fork
			send(1'h0, w);
			if (n > 32) begin
				repeat (80) @(negedge clk);
				chk("tx full", 33'h0, 33'(u_tec_if.tx_ready));
				hold <= 1'h0;
			end
		join
		repeat (n + 30) @(negedge clk);
		chk("tx count", 33'(e.size()), 33'(txq.size()));
		foreach (e[i]) chk("tx word", e[i], txq[i]);
		foreach (e[i]) chk("tx start", 33'(i == 0), 33'(tsq[i]));
	endtask

	task automatic complete_run;
		if (fails == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		complete_run();
	end

	initial begin
		repeat (2) @(negedge clk);
		arst_n = 1'h1;
		for (int k = 0; k < 16; k++) rx_case(k[3], k[2], k[1], k[0]);
		tx_case(1'h1, 1'h0, 1'h1, 5);
		tx_case(1'h0, 1'h0, 1'h1, 3);
		tx_case(1'h1, 1'h0, 1'h0, 3);
		tx_case(1'h0, 1'h1, 1'h1, 40);
		tx_case(1'h1, 1'h1, 1'h1, 2);
		complete_run();
	end
endmodule // test_tlp_ecrc_check_generate
